// file: verilog/incmov_pkg.sv
// shared widths, reset values, operation and state encodings
package incmov_pkg;
  // ==========================================
  // widths and reset values
  localparam int DATA_W = 8;
  localparam int INDEX_W = 5;
  localparam int FILE_COUNT = 32;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic NULL_FLAG_RESET = 1'b0;
  localparam int SKIP_IDLE_CYCLES = 1;
  // target_choice encodings
  localparam logic TARGET_ACC = 1'b0;
  localparam logic TARGET_FILE = 1'b1;

  // ==========================================
  // operation select
  typedef enum logic [2:0] {
    idle_op = 3'h0,
    increment_file = 3'h1,
    increment_skip_null = 3'h2,
    or_literal_acc = 3'h3,
    or_acc_file = 3'h4,
    copy_acc_to_file = 3'h5,
    copy_file = 3'h6,
    load_literal_acc = 3'h7
  } op_t;

  // ==========================================
  // sequencing states
  typedef enum logic [1:0] {
    st_run = 2'b01,
    st_skip_slot = 2'b10
  } seq_state_t;
endpackage

// file: verilog/incmov_alu_if.sv
// operands and results between the sequencer and the arithmetic unit
`timescale 1ns/100ps
interface incmov_alu_if #(
  parameter int DATA_W = 8
);
  incmov_pkg::op_t op;
  logic target_choice;
  logic [DATA_W-1:0] acc_value;
  logic [DATA_W-1:0] file_value;
  logic [DATA_W-1:0] literal_value;
  logic [DATA_W-1:0] result;
  logic write_acc;
  logic write_file;
  logic update_null;
  logic skip_request;

  modport seq (
    output op,
    output target_choice,
    output acc_value,
    output file_value,
    output literal_value,
    input result,
    input write_acc,
    input write_file,
    input update_null,
    input skip_request
  );
  modport alu (
    input op,
    input target_choice,
    input acc_value,
    input file_value,
    input literal_value,
    output result,
    output write_acc,
    output write_file,
    output update_null,
    output skip_request
  );
endinterface

// file: verilog/incmov_alu.sv
// combinational result, destination and flag decisions per operation
`timescale 1ns/100ps
module incmov_alu (
  incmov_alu_if.alu bus
);
  // ==========================================
  // result and destination
  always_comb
  begin
    bus.result = bus.file_value;
    bus.write_acc = 1'b0;
    bus.write_file = 1'b0;
    bus.update_null = 1'b0;
    bus.skip_request = 1'b0;
    case (bus.op)
      incmov_pkg::increment_file:
      begin
        bus.result = bus.file_value + 8'h01;
        bus.write_acc = (bus.target_choice == incmov_pkg::TARGET_ACC);
        bus.write_file = (bus.target_choice == incmov_pkg::TARGET_FILE);
        bus.update_null = 1'b1;
      end
      incmov_pkg::increment_skip_null:
      begin
        bus.result = bus.file_value + 8'h01;
        bus.write_acc = (bus.target_choice == incmov_pkg::TARGET_ACC);
        bus.write_file = (bus.target_choice == incmov_pkg::TARGET_FILE);
        // wrap from ff to 00 is the only zero result
        bus.skip_request = (bus.file_value == 8'hff);
      end
      incmov_pkg::or_literal_acc:
      begin
        bus.result = bus.acc_value | bus.literal_value;
        bus.write_acc = 1'b1;
        bus.update_null = 1'b1;
      end
      incmov_pkg::or_acc_file:
      begin
        bus.result = bus.acc_value | bus.file_value;
        bus.write_acc = (bus.target_choice == incmov_pkg::TARGET_ACC);
        bus.write_file = (bus.target_choice == incmov_pkg::TARGET_FILE);
        bus.update_null = 1'b1;
      end
      incmov_pkg::copy_acc_to_file:
      begin
        bus.result = bus.acc_value;
        bus.write_file = 1'b1;
      end
      incmov_pkg::copy_file:
      begin
        bus.result = bus.file_value;
        bus.write_acc = (bus.target_choice == incmov_pkg::TARGET_ACC);
        bus.write_file = (bus.target_choice == incmov_pkg::TARGET_FILE);
        bus.update_null = 1'b1;
      end
      incmov_pkg::load_literal_acc:
      begin
        bus.result = bus.literal_value;
        bus.write_acc = 1'b1;
      end
      default:
      begin
        bus.result = bus.file_value;
      end
    endcase
  end
endmodule // incmov_alu

// file: verilog/incmov_datapath.sv
// increment, or and move datapath with accumulator, file registers and null flag
// Function
// - increment adds one to addressed file register, stores result, updates null flag.
// - target_choice 0 writes accumulator, 1 writes back to file register.
// - increment-skip stores like increment, no flag change; zero result adds idle cycle.
// - or-literal ors accumulator with literal into accumulator, updates null flag.
// - or-file ors accumulator with file register to chosen destination, updates flag.
// - copy accumulator into addressed file register, flags untouched.
// - copy file to destination updating flag; target 1 acts as zero test.
// - load literal into accumulator, flags untouched.
`timescale 1ns/100ps
module incmov_datapath #(
  parameter int FILE_COUNT = incmov_pkg::FILE_COUNT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire incmov_pkg::op_t op_select,
  input wire logic [4:0] register_index,
  input wire logic target_choice,
  input wire logic [7:0] literal_value,
  input wire logic [4:0] peek_index,
  output logic instr_done,
  output logic discard_next,
  output logic [7:0] acc_value,
  output logic null_result_flag,
  output logic [7:0] peek_data
);
  // ==========================================
  // elaboration check
  if (FILE_COUNT < 1 || FILE_COUNT > 32)
  begin : bad_file_count
    $error("FILE_COUNT must lie in 1..32");
  end

  // ==========================================
  // storage and state
  logic [7:0] file_ff [FILE_COUNT];
  logic [7:0] acc_ff;
  logic null_ff;
  logic done_ff;
  logic [7:0] peek_ff;
  incmov_pkg::seq_state_t state_ff;
  incmov_pkg::seq_state_t nxt_state;
  logic take;
  logic in_range;
  logic [7:0] sel_file;

  incmov_alu_if #(.DATA_W(incmov_pkg::DATA_W)) alu_bus ();

  incmov_alu u_alu (
    .bus(alu_bus)
  );

  // out-of-range indices read zero and drop writes
  assign in_range = (32'(register_index) < FILE_COUNT);
  assign sel_file = in_range ? file_ff[register_index] : 8'h00;
  // the instruction fetched behind a taken skip is swallowed here
  assign take = instr_valid && (state_ff == incmov_pkg::st_run);

  assign alu_bus.op = op_select;
  assign alu_bus.target_choice = target_choice;
  assign alu_bus.acc_value = acc_ff;
  assign alu_bus.file_value = sel_file;
  assign alu_bus.literal_value = literal_value;

  // ==========================================
  // sequencing
  always_comb
  begin
    nxt_state = incmov_pkg::st_run;
    case (state_ff)
      incmov_pkg::st_run:
      begin
        if (take && alu_bus.skip_request)
        begin
          nxt_state = incmov_pkg::st_skip_slot;
        end
      end
      incmov_pkg::st_skip_slot:
      begin
        nxt_state = incmov_pkg::st_run;
      end
      default:
      begin
        nxt_state = incmov_pkg::st_run;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= incmov_pkg::st_run;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      // single-cycle completion, skip adds the idle slot
      done_ff <= take && !alu_bus.skip_request;
      if (state_ff == incmov_pkg::st_skip_slot)
      begin
        done_ff <= 1'b1;
      end
    end
  end

  // ==========================================
  // accumulator and flag
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_ff <= incmov_pkg::ACC_RESET;
    end
    else if (take && alu_bus.write_acc)
    begin
      acc_ff <= alu_bus.result;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      null_ff <= incmov_pkg::NULL_FLAG_RESET;
    end
    else if (take && alu_bus.update_null)
    begin
      null_ff <= (alu_bus.result == 8'h00);
    end
  end

  // ==========================================
  // file registers
  for (genvar i = 0; i < FILE_COUNT; i++)
  begin : g_file
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        file_ff[i] <= incmov_pkg::FILE_RESET;
      end
      else if (take && alu_bus.write_file && (32'(register_index) == i))
      begin
        file_ff[i] <= alu_bus.result;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      peek_ff <= 8'h00;
    end
    else
    begin
      peek_ff <= (32'(peek_index) < FILE_COUNT) ? file_ff[peek_index] : 8'h00;
    end
  end

  assign instr_done = done_ff;
  assign discard_next = (state_ff == incmov_pkg::st_skip_slot);
  assign acc_value = acc_ff;
  assign null_result_flag = null_ff;
  assign peek_data = peek_ff;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // operands come in as arguments so the checks see sampled values, not post-edge ones
  function automatic logic is_op(logic t, incmov_pkg::op_t s, incmov_pkg::op_t o);
    return t && (s == o);
  endfunction

  sequence skip_taken_s;
    is_op(take, op_select, incmov_pkg::increment_skip_null) && (sel_file == 8'hff);
  endsequence
  sequence idle_then_run_s;
    (state_ff == incmov_pkg::st_skip_slot) ##1 (state_ff == incmov_pkg::st_run);
  endsequence

  inc_to_acc_a: assert property (
    is_op(take, op_select, incmov_pkg::increment_file) && !target_choice
    |=> acc_ff == 8'($past(sel_file) + 8'h01) && null_ff == (acc_ff == 8'h00))
    else $error("increment to accumulator wrong");
  file_target_a: assert property (
    take && target_choice && op_select != incmov_pkg::load_literal_acc
    && op_select != incmov_pkg::or_literal_acc |=> $stable(acc_ff))
    else $error("accumulator changed for file target");
  skip_slot_a: assert property (
    skip_taken_s |=> idle_then_run_s and !instr_done ##1 instr_done)
    else $error("taken skip did not idle one cycle");
  skip_flag_a: assert property (
    is_op(take, op_select, incmov_pkg::increment_skip_null) |=> $stable(null_ff))
    else $error("skip form touched null flag");
  or_literal_a: assert property (
    is_op(take, op_select, incmov_pkg::or_literal_acc)
    |=> acc_ff == ($past(acc_ff) | $past(literal_value)))
    else $error("or with literal wrong");
  or_file_flag_a: assert property (
    is_op(take, op_select, incmov_pkg::or_acc_file)
    |=> null_ff == (($past(acc_ff) | $past(sel_file)) == 8'h00))
    else $error("or with file flag wrong");
  copy_acc_a: assert property (
    is_op(take, op_select, incmov_pkg::copy_acc_to_file) && in_range
    |=> file_ff[$past(register_index)] == $past(acc_ff) && $stable(null_ff))
    else $error("copy accumulator to file wrong");
  zero_test_a: assert property (
    is_op(take, op_select, incmov_pkg::copy_file) && target_choice
    |=> null_ff == ($past(sel_file) == 8'h00) && $stable(acc_ff))
    else $error("file zero test wrong");
  load_literal_a: assert property (
    is_op(take, op_select, incmov_pkg::load_literal_acc)
    |=> acc_ff == $past(literal_value) && $stable(null_ff))
    else $error("load literal wrong");
  flag_rule_a: assert property (
    take && alu_bus.update_null |=> null_ff == ($past(alu_bus.result) == 8'h00))
    else $error("null flag does not follow result");
  idle_op_a: assert property (
    is_op(take, op_select, incmov_pkg::idle_op)
    |=> $stable(acc_ff) && $stable(null_ff) && instr_done)
    else $error("idle instruction changed state");
  skip_drop_a: assert property (
    discard_next && instr_valid |=> $stable(acc_ff) && $stable(null_ff))
    else $error("discarded instruction left a trace");
endmodule // incmov_datapath

// file: verif/increment_or_move_datapath_tb.sv
// self-checking bench for the increment, or and move datapath
`timescale 1ns/100ps
module increment_or_move_datapath_tb;
  // ==========================================
  // stimulus rows
  typedef struct packed {
    incmov_pkg::op_t op;
    logic [4:0] idx;
    logic tgt;
    logic [7:0] lit;
    logic [7:0] acc;
    logic flag;
    logic [7:0] file;
    logic skip;
  } row_t;
  localparam incmov_pkg::op_t op_nop = incmov_pkg::idle_op;
  localparam incmov_pkg::op_t op_inc = incmov_pkg::increment_file;
  localparam incmov_pkg::op_t op_isz = incmov_pkg::increment_skip_null;
  localparam incmov_pkg::op_t op_orl = incmov_pkg::or_literal_acc;
  localparam incmov_pkg::op_t op_orf = incmov_pkg::or_acc_file;
  localparam incmov_pkg::op_t op_mvw = incmov_pkg::copy_acc_to_file;
  localparam incmov_pkg::op_t op_mvf = incmov_pkg::copy_file;
  localparam incmov_pkg::op_t op_ld = incmov_pkg::load_literal_acc;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  incmov_pkg::op_t op_select = incmov_pkg::idle_op;
  logic [4:0] register_index = 5'h00;
  logic target_choice = 1'b0;
  logic [7:0] literal_value = 8'h00;
  logic [4:0] peek_index = 5'h00;
  logic instr_done;
  logic discard_next;
  logic [7:0] acc_value;
  logic null_result_flag;
  logic [7:0] peek_data;
  int fails = 0;
  int total_checks = 0;
  // each row leans on the state left by the rows above it
  row_t rows [20] = '{
    '{op_ld, 5'h00, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0},
    '{op_orl, 5'h00, 1'b0, 8'h00, 8'h00, 1'b1, 8'h00, 1'b0},
    '{op_ld, 5'h00, 1'b0, 8'ha5, 8'ha5, 1'b1, 8'h00, 1'b0},
    '{op_mvw, 5'h1f, 1'b0, 8'h00, 8'ha5, 1'b1, 8'ha5, 1'b0},
    '{op_inc, 5'h1f, 1'b0, 8'h00, 8'ha6, 1'b0, 8'ha5, 1'b0},
    '{op_inc, 5'h1f, 1'b1, 8'h00, 8'ha6, 1'b0, 8'ha6, 1'b0},
    '{op_ld, 5'h00, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0},
    '{op_mvf, 5'h00, 1'b1, 8'h00, 8'h00, 1'b1, 8'h00, 1'b0},
    '{op_nop, 5'h1f, 1'b1, 8'hff, 8'h00, 1'b1, 8'ha6, 1'b0},
    '{op_orf, 5'h1f, 1'b0, 8'h00, 8'ha6, 1'b0, 8'ha6, 1'b0},
    '{op_mvw, 5'h02, 1'b0, 8'h00, 8'ha6, 1'b0, 8'ha6, 1'b0},
    '{op_ld, 5'h02, 1'b0, 8'h19, 8'h19, 1'b0, 8'ha6, 1'b0},
    '{op_orf, 5'h02, 1'b1, 8'h00, 8'h19, 1'b0, 8'hbf, 1'b0},
    '{op_mvf, 5'h02, 1'b0, 8'h00, 8'hbf, 1'b0, 8'hbf, 1'b0},
    '{op_ld, 5'h06, 1'b0, 8'hff, 8'hff, 1'b0, 8'h00, 1'b0},
    '{op_mvw, 5'h06, 1'b0, 8'h00, 8'hff, 1'b0, 8'hff, 1'b0},
    '{op_inc, 5'h06, 1'b1, 8'h00, 8'hff, 1'b1, 8'h00, 1'b0},
    '{op_isz, 5'h1f, 1'b1, 8'h00, 8'hff, 1'b1, 8'ha7, 1'b0},
    '{op_mvw, 5'h05, 1'b0, 8'h00, 8'hff, 1'b1, 8'hff, 1'b0},
    '{op_isz, 5'h05, 1'b1, 8'h00, 8'hff, 1'b1, 8'h00, 1'b1}
  };

  always #50 clk = ~clk;

  incmov_datapath #(.FILE_COUNT(32)) incmov_datapath_i (
    .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .op_select(op_select),
    .register_index(register_index), .target_choice(target_choice),
    .literal_value(literal_value), .peek_index(peek_index), .instr_done(instr_done),
    .discard_next(discard_next), .acc_value(acc_value),
    .null_result_flag(null_result_flag), .peek_data(peek_data)
  );

  // ==========================================
  // checking and driving tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_reset();
    chk(acc_value, incmov_pkg::ACC_RESET);
    chk({7'h00, null_result_flag}, {7'h00, incmov_pkg::NULL_FLAG_RESET});
    chk({6'h00, instr_done, discard_next}, 8'h00);
    chk(peek_data, 8'h00);
  endtask

  task automatic exec(input row_t r, input logic follow);
    int n;
    logic sk;
    @(posedge clk);
    instr_valid <= 1'b1;
    op_select <= r.op;
    // literal load leaves its unused operand fields at zero
    register_index <= (r.op == op_ld) ? 5'h00 : r.idx;
    target_choice <= (r.op == op_ld) ? 1'b0 : r.tgt;
    literal_value <= r.lit;
    peek_index <= r.idx;
    @(posedge clk);
    // the follower sits in the idle slot and must leave no trace
    if (follow)
    begin
      op_select <= op_ld;
      literal_value <= 8'h55;
      register_index <= 5'h00;
      target_choice <= 1'b0;
    end
    else
      instr_valid <= 1'b0;
    #1;
    n = 0;
    sk = (discard_next === 1'b1);
    while (instr_done !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      n++;
      if (discard_next === 1'b1) sk = 1'b1;
    end
    chk(8'(n + 1), 8'(1 + (r.skip ? incmov_pkg::SKIP_IDLE_CYCLES : 0)));
    chk({7'h00, sk}, {7'h00, r.skip});
    chk(acc_value, r.acc);
    chk({7'h00, null_result_flag}, {7'h00, r.flag});
    repeat (2) @(posedge clk);
    #1;
    chk(peek_data, r.file);
  endtask

  task end_sim();
    $display("checks %0d failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================
  // test sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    chk_reset();
    @(posedge clk);
    reset_n <= 1'b1;
    $display("test reset values done");
    for (int i = 0; i < 20; i++) exec(rows[i], 1'b0);
    $display("test table rows done");
    exec(row_t'{op_mvw, 5'h07, 1'b0, 8'h00, 8'hff, 1'b1, 8'hff, 1'b0}, 1'b0);
    exec(row_t'{op_isz, 5'h07, 1'b0, 8'h00, 8'h00, 1'b1, 8'hff, 1'b1}, 1'b1);
    $display("test skip with dropped follower done");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_reset();
    @(posedge clk);
    reset_n <= 1'b1;
    exec(row_t'{op_nop, 5'h1f, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0}, 1'b0);
    $display("test mid-run reset done");
    end_sim();
  end

  // about 110 cycles are needed; a hang is cut off well beyond that
  initial
  begin
    #(100 * 2000);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
endmodule // increment_or_move_datapath_tb
